// *** acmc_defines.svh ***
// Register map, field positions, reset values and timing counts
`ifndef ACMC_DEFINES_SVH
`define ACMC_DEFINES_SVH
`define ACMC_ADDR_W        8
`define ACMC_ADDR_CFG      8'h00
`define ACMC_ADDR_RES      8'h04
`define ACMC_ADDR_STAT     8'h08
`define ACMC_CFG_SEL_LSB   0
`define ACMC_CFG_MODE_BIT  8
`define ACMC_CFG_SS_BIT    15
`define ACMC_CFG_SEL_RST   3'h0
`define ACMC_CFG_MODE_RST  1'b1
`define ACMC_STAT_BUSY     0
`define ACMC_STAT_NEW      1
`define ACMC_STAT_GND      2
`define ACMC_STAT_TO       3
`define ACMC_CODE_W        24
`define ACMC_PCLK_NS       5
`define ACMC_SCLK_TO_US    30800
`define ACMC_SCLK_TO_CYC   ((`ACMC_SCLK_TO_US * 1000 + `ACMC_PCLK_NS - 1) / `ACMC_PCLK_NS)
`define ACMC_CONV_CYC      200
`endif

// *** acmc_pkg.sv ***
// Types shared by the conversion control block
package acmc_pkg;
`include "acmc_defines.svh"
	typedef enum logic [1:0] {
		ACMC_PDOWN = 2'b00,
		ACMC_CONV  = 2'b01
	} acmc_state_t;

	typedef struct packed {
		logic       mode;
		logic [2:0] sel;
	} acmc_cfg_t;

	typedef struct packed {
		logic                    rdy;
		logic [`ACMC_CODE_W-1:0] code;
	} acmc_snap_t;

	typedef struct packed {
		logic [1:0] pos;
		logic [1:0] neg;
		logic       gnd_sw;
	} acmc_route_t;
endpackage : acmc_pkg

// *** acmc_input_mux.sv ***
// Input selector and signed difference of the selected pair
`timescale 1ns/1ps
`include "acmc_defines.svh"
module acmc_input_mux import acmc_pkg::*; #(
	parameter int W = `ACMC_CODE_W
) (
	// Selection
	input  wire logic [2:0]        sel,
	// Channel samples
	input  wire logic signed [W-1:0] analog_in_zero,
	input  wire logic signed [W-1:0] analog_in_one,
	input  wire logic signed [W-1:0] analog_in_two,
	input  wire logic signed [W-1:0] analog_in_three,
	// Routed pair and result
	output acmc_route_t              route,
	output logic signed [W-1:0]      positive_converter_input,
	output logic signed [W-1:0]      negative_converter_input,
	output logic signed [W-1:0]      diff
);
	logic signed [W-1:0] ain [4];
	logic signed [W:0]   wide;

	// Fixed pair table, codes 4..7 are single-ended against ground
	function automatic acmc_route_t route_of(input logic [2:0] s);
		case (s)
			3'h0: route_of = '{pos: 2'h0, neg: 2'h1, gnd_sw: 1'b0};
			3'h1: route_of = '{pos: 2'h0, neg: 2'h3, gnd_sw: 1'b0};
			3'h2: route_of = '{pos: 2'h1, neg: 2'h3, gnd_sw: 1'b0};
			3'h3: route_of = '{pos: 2'h2, neg: 2'h3, gnd_sw: 1'b0};
			default: route_of = '{pos: s[1:0], neg: 2'h0, gnd_sw: 1'b1};
		endcase
	endfunction : route_of

	assign ain[0] = analog_in_zero;
	assign ain[1] = analog_in_one;
	assign ain[2] = analog_in_two;
	assign ain[3] = analog_in_three;
	assign route  = route_of(sel);

	always_comb begin
		positive_converter_input = ain[route.pos];
		// Grounding switch replaces the negative leg
		negative_converter_input = route.gnd_sw ? '0 : ain[route.neg];
		wide = {positive_converter_input[W-1], positive_converter_input}
			- {negative_converter_input[W-1], negative_converter_input};
		// Saturate rather than wrap on a full-scale pair
		if (wide[W] != wide[W-1]) begin
			diff = wide[W] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
		end else begin
			diff = wide[W-1:0];
		end
		if (route.gnd_sw && diff[W-1]) begin
			diff = '0;
		end
	end
endmodule : acmc_input_mux

// *** acmc_top.sv ***
// Conversion control, input selection and serial link timeout
// Functional notes
// - Serial clock low past the timeout resets the serial interface logic.
// - Timeout with chip select low also clears the held conversion code.
// - Single-shot mode: one conversion per request, then back to power-down.
// - Continuous mode converts back to back; reads give the latest result.
// - A three-bit selection field in configuration steers the converter inputs.
// - Four single-ended inputs, the pair 0 minus 1, and inputs 0..2 against input 3.
// - Single-ended selection ties the negative converter input to ground.
// - Result is signed positive minus negative input.
// - No negative code while a single-ended input is selected.
// - Mode bit one selects single-shot, zero continuous; host writes it.
// - Writing trigger one powers up, trigger reads zero, one conversion starts.
// - Trigger write during a running conversion is ignored.
// - Reset gives default configuration: power-down, interface alive, idle.
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`include "acmc_defines.svh"
module acmc_top import acmc_pkg::*; #(
	parameter int TO_CYCLES   = `ACMC_SCLK_TO_CYC,
	parameter int CONV_CYCLES = `ACMC_CONV_CYC,
	parameter int CODE_W      = `ACMC_CODE_W
) (
	// Clock, reset, enable
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    ce,
	// APB slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [`ACMC_ADDR_W-1:0] paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	// Serial link
	input  wire logic                    serial_clk,
	input  wire logic                    chip_sel_n,
	output logic                         serial_out_with_ready,
	output logic                         serial_out_oe,
	// Channel samples from the modulator
	input  wire logic signed [CODE_W-1:0] analog_in_zero,
	input  wire logic signed [CODE_W-1:0] analog_in_one,
	input  wire logic signed [CODE_W-1:0] analog_in_two,
	input  wire logic signed [CODE_W-1:0] analog_in_three,
	// Analog control
	output logic signed [CODE_W-1:0]      positive_converter_input,
	output logic signed [CODE_W-1:0]      negative_converter_input,
	output logic                         ground_switch_on,
	output logic                         converter_powered
);
	localparam int TOW  = $clog2(TO_CYCLES + 1);
	localparam int CVW  = $clog2(CONV_CYCLES + 1);
	localparam int CNTW = $clog2(CODE_W + 1);

	acmc_state_t             state_r;
	acmc_cfg_t               cfg_r;
	acmc_route_t             route;
	acmc_snap_t              snap_r;
	logic [CVW-1:0]          conv_cnt_r;
	logic [TOW-1:0]          to_cnt_r;
	logic signed [CODE_W-1:0] diff;
	logic [CODE_W-1:0]       result_r;
	logic                    new_r;
	logic                    to_rst_r;
	logic                    to_seen_r;
	logic                    sclk_m_r;
	logic                    sclk_s_r;
	logic                    cs_m_r;
	logic                    cs_s_r;
	logic                    cs_d_r;
	logic [31:0]             prdata_r;
	logic                    wr_en;
	logic                    rd_res;
	logic                    cfg_wr;
	logic                    ss_req;
	logic                    conv_done;
	logic                    to_hit;
	logic                    frame_start;
	logic                    link_rst_n;
	logic [CNTW-1:0]         bit_cnt_r;
	logic [CNTW-1:0]         bit_idx;
	logic                    sout_r;

	function automatic logic is_mapped(input logic [`ACMC_ADDR_W-1:0] a);
		is_mapped = (a == `ACMC_ADDR_CFG) || (a == `ACMC_ADDR_RES) || (a == `ACMC_ADDR_STAT);
	endfunction : is_mapped

	// Bus
	assign pready  = ce;
	assign pslverr = psel && penable && !is_mapped(paddr);
	assign prdata  = prdata_r;
	assign wr_en   = psel && penable && pwrite && ce;
	assign cfg_wr  = wr_en && (paddr == `ACMC_ADDR_CFG);
	assign ss_req  = cfg_wr && pwdata[`ACMC_CFG_SS_BIT];
	assign rd_res  = psel && penable && !pwrite && ce && (paddr == `ACMC_ADDR_RES);

	// Read data is staged in the setup phase so it comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0;
		end else if (ce && psel && !penable) begin
			case (paddr)
				`ACMC_ADDR_CFG: prdata_r <= {16'h0, 7'h0, cfg_r.mode, 5'h0, cfg_r.sel};
				`ACMC_ADDR_RES: prdata_r <= {{(32-CODE_W){1'b0}}, result_r};
				`ACMC_ADDR_STAT: prdata_r <= {28'h0, to_seen_r, ground_switch_on, new_r,
					state_r == ACMC_CONV};
				default: prdata_r <= 32'h0;
			endcase
		end
	end

	// Configuration; trigger bit is not stored so it always reads zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_r.mode <= `ACMC_CFG_MODE_RST;
			cfg_r.sel  <= `ACMC_CFG_SEL_RST;
		end else if (cfg_wr) begin
			cfg_r.mode <= pwdata[`ACMC_CFG_MODE_BIT];
			cfg_r.sel  <= pwdata[`ACMC_CFG_SEL_LSB +: 3];
		end
	end

	acmc_input_mux #(
		.W (CODE_W)
	) u_mux (
		.sel                      (cfg_r.sel),
		.analog_in_zero           (analog_in_zero),
		.analog_in_one            (analog_in_one),
		.analog_in_two            (analog_in_two),
		.analog_in_three          (analog_in_three),
		.route                    (route),
		.positive_converter_input (positive_converter_input),
		.negative_converter_input (negative_converter_input),
		.diff                     (diff)
	);
	assign ground_switch_on  = route.gnd_sw;
	assign converter_powered = (state_r == ACMC_CONV);

	// Conversion sequencer
	assign conv_done = ce && (state_r == ACMC_CONV) && (conv_cnt_r == CVW'(CONV_CYCLES - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r    <= ACMC_PDOWN;
			conv_cnt_r <= '0;
		end else if (ce) begin
			case (state_r)
				ACMC_PDOWN: begin
					// A mode write to continuous starts at once
					if (ss_req || !cfg_r.mode) begin
						state_r    <= ACMC_CONV;
						conv_cnt_r <= '0;
					end
				end
				ACMC_CONV: begin
					if (conv_done) begin
						conv_cnt_r <= '0;
						if (cfg_r.mode) begin
							state_r <= ACMC_PDOWN;
						end
					end else begin
						conv_cnt_r <= conv_cnt_r + 1'b1;
					end
				end
				default: begin
					state_r    <= ACMC_PDOWN;
					conv_cnt_r <= '0;
				end
			endcase
		end
	end

	// Result holds the latest completed conversion until a timeout with chip select low clears it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_r <= '0;
		end else if (ce) begin
			if (conv_done) begin
				result_r <= diff;
			end else if (to_hit && !cs_s_r) begin
				result_r <= '0;
			end
		end
	end

	// Data-ready flag: a completion in the clearing cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			new_r <= 1'b0;
		end else if (ce) begin
			if (conv_done) begin
				new_r <= 1'b1;
			end else if (frame_start || rd_res) begin
				new_r <= 1'b0;
			end
		end
	end

	// Pin synchronisers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sclk_m_r <= 1'b0;
			sclk_s_r <= 1'b0;
			cs_m_r   <= 1'b1;
			cs_s_r   <= 1'b1;
			cs_d_r   <= 1'b1;
		end else if (ce) begin
			sclk_m_r <= serial_clk;
			sclk_s_r <= sclk_m_r;
			cs_m_r   <= chip_sel_n;
			cs_s_r   <= cs_m_r;
			cs_d_r   <= cs_s_r;
		end
	end
	assign frame_start = cs_d_r && !cs_s_r;

	// Serial clock low timeout
	assign to_hit = ce && !sclk_s_r && (to_cnt_r == TOW'(TO_CYCLES - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			to_cnt_r  <= '0;
			to_rst_r  <= 1'b0;
			to_seen_r <= 1'b0;
		end else if (ce) begin
			if (sclk_s_r) begin
				to_cnt_r <= '0;
				to_rst_r <= 1'b0;
			end else if (to_cnt_r != TOW'(TO_CYCLES)) begin
				to_cnt_r <= to_cnt_r + 1'b1;
			end
			if (to_hit) begin
				to_rst_r  <= 1'b1;
				to_seen_r <= 1'b1;
			end else if (frame_start) begin
				// Rearm the link, else the first edge of the new frame is lost
				to_rst_r  <= 1'b0;
				to_seen_r <= 1'b0;
			end
		end
	end

	// Snapshot is frozen while a frame runs, so the link reads a stable word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			snap_r <= '0;
		end else if (ce && cs_s_r) begin
			snap_r <= '{rdy: new_r, code: result_r};
		end
	end

	// Link domain; held in reset while deselected or after a timeout
	assign link_rst_n = presetn && !to_rst_r && !chip_sel_n;
	assign bit_idx    = CNTW'(CODE_W - 1) - bit_cnt_r;

	always_ff @(posedge serial_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			bit_cnt_r <= '0;
			sout_r    <= 1'b1;
		end else if (bit_cnt_r != CNTW'(CODE_W)) begin
			sout_r    <= snap_r.code[bit_idx];
			bit_cnt_r <= bit_cnt_r + 1'b1;
		end else begin
			sout_r <= 1'b1;
		end
	end

	// Before the first edge the pin shows data ready, active low
	assign serial_out_with_ready = (bit_cnt_r == '0) ? !snap_r.rdy : sout_r;
	assign serial_out_oe         = !chip_sel_n;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_to_reset;
		!sclk_s_r && ce && (to_cnt_r == TOW'(TO_CYCLES - 1)) |=> to_rst_r && !link_rst_n;
	endproperty
	a_to_reset: assert property (p_to_reset) else $error("no link reset on timeout");

	property p_to_clear;
		to_hit && !cs_s_r && !conv_done |=> result_r == '0;
	endproperty
	a_to_clear: assert property (p_to_clear) else $error("code not cleared");

	property p_single_end;
		conv_done && cfg_r.mode |=> state_r == ACMC_PDOWN ##1 (state_r == ACMC_PDOWN || $past(ss_req));
	endproperty
	a_single_end: assert property (p_single_end) else $error("no power-down");

	property p_cont_next;
		conv_done && !cfg_r.mode |=> state_r == ACMC_CONV && result_r == $past(diff);
	endproperty
	a_cont_next: assert property (p_cont_next) else $error("continuous restart");

	property p_gnd;
		cfg_r.sel[2] |-> ground_switch_on && negative_converter_input == '0;
	endproperty
	a_gnd: assert property (p_gnd) else $error("ground switch open");

	property p_no_neg;
		conv_done && route.gnd_sw |=> !result_r[CODE_W-1];
	endproperty
	a_no_neg: assert property (p_no_neg) else $error("negative single-ended");

	property p_mode_cont;
		cfg_wr && !pwdata[`ACMC_CFG_MODE_BIT] ##1 ce && state_r == ACMC_PDOWN |=> state_r == ACMC_CONV;
	endproperty
	a_mode_cont: assert property (p_mode_cont) else $error("mode write ignored");

	property p_ss_start;
		ss_req && state_r == ACMC_PDOWN |=> state_r == ACMC_CONV && conv_cnt_r == '0;
	endproperty
	a_ss_start: assert property (p_ss_start) else $error("trigger ignored");

	property p_ss_busy;
		ss_req && state_r == ACMC_CONV && !conv_done |=> conv_cnt_r == $past(conv_cnt_r) + 1'b1;
	endproperty
	a_ss_busy: assert property (p_ss_busy) else $error("trigger restarted");

	property p_frame_rearm;
		ce && frame_start && !to_hit |=> !to_rst_r;
	endproperty
	a_frame_rearm: assert property (p_frame_rearm) else $error("link still held");

	property p_new_flag;
		conv_done |=> new_r;
	endproperty
	a_new_flag: assert property (p_new_flag) else $error("no data-ready flag");

	property p_pdown_idle;
		ce && state_r == ACMC_PDOWN && cfg_r.mode && !ss_req |=> state_r == ACMC_PDOWN;
	endproperty
	a_pdown_idle: assert property (p_pdown_idle) else $error("woke without trigger");

	property p_pair_open;
		!cfg_r.sel[2] |-> !ground_switch_on;
	endproperty
	a_pair_open: assert property (p_pair_open) else $error("ground switch on a pair");

	c_single: cover property (conv_done && cfg_r.mode);
	c_cont: cover property (conv_done && !cfg_r.mode ##[1:1000] conv_done);
	c_timeout: cover property (to_hit);
	c_timeout_cs: cover property (to_hit && !cs_s_r);
endmodule : acmc_top

// *** acmc_host_model.sv ***
// Host side model of the serial link: framing, bit reads and clock stalls
`timescale 1ns/1ps
module acmc_host_model (
	// Link pins
	output logic      serial_clk,
	output logic      chip_sel_n,
	input  wire logic serial_out_with_ready,
	input  wire logic serial_out_oe
);
	// A released line is not trusted, so it reads as unknown
	function automatic logic line();
		return (serial_out_oe === 1'b1) ? serial_out_with_ready : 1'bx;
	endfunction : line

	initial begin
		serial_clk = 1'b0;
		chip_sel_n = 1'b1;
	end

	// Clock runs only inside a frame, 48 ns period, bits read on the fall
	task automatic frame(input int nbits, output logic rdy_n, output logic [23:0] code);
		chip_sel_n = 1'b0;
		#100;
		rdy_n = line();
		code = '0;
		for (int i = 0; i < nbits; i++) begin
			serial_clk = 1'b1;
			#24;
			serial_clk = 1'b0;
			code = {code[22:0], line()};
			#24;
		end
	endtask : frame

	// Clock held low with the frame open, long enough to hit the timeout
	task automatic stall(input int ns);
		#(ns);
	endtask : stall

	task automatic close();
		#100;
		chip_sel_n = 1'b1;
		#200;
	endtask : close
endmodule : acmc_host_model

// *** adc_conversion_mux_control_tb.sv ***
// Self-checking bench for conversion control, input selection and link timeout
`timescale 1ns/1ps
`include "acmc_defines.svh"
module adc_conversion_mux_control_tb;
	// Short counts keep the run brief
	localparam int          TO   = 50;
	localparam int          CV   = 20;
	localparam logic [7:0]  CFG  = `ACMC_ADDR_CFG;
	localparam logic [7:0]  RES  = `ACMC_ADDR_RES;
	localparam logic [7:0]  STAT = `ACMC_ADDR_STAT;
	localparam logic [31:0] TRIG = 32'h1 << `ACMC_CFG_SS_BIT;
	localparam logic [31:0] MODE = 32'h1 << `ACMC_CFG_MODE_BIT;

	logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic [7:0]         paddr;
	logic [31:0]        pwdata, prdata, rdat;
	logic               serial_clk, chip_sel_n, sdo, sdo_oe, gnd_on, powered, r;
	logic [23:0]        c;
	logic signed [23:0] ain [4];
	logic signed [23:0] pos_in, neg_in;
	int                 n_errors, compares, cyc;

	acmc_top #(.TO_CYCLES(TO), .CONV_CYCLES(CV)) i_dut (
		.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .serial_clk(serial_clk),
		.chip_sel_n(chip_sel_n), .serial_out_with_ready(sdo), .serial_out_oe(sdo_oe),
		.analog_in_zero(ain[0]), .analog_in_one(ain[1]), .analog_in_two(ain[2]),
		.analog_in_three(ain[3]), .positive_converter_input(pos_in),
		.negative_converter_input(neg_in), .ground_switch_on(gnd_on),
		.converter_powered(powered)
	);

	acmc_host_model i_host (
		.serial_clk(serial_clk), .chip_sel_n(chip_sel_n),
		.serial_out_with_ready(sdo), .serial_out_oe(sdo_oe)
	);

	initial pclk = 1'b0;
	always #2.5 pclk = ~pclk;

	// Hang guard, far above the expected run of under two thousand cycles
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			wrap_up();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Wait for pready; only the hang guard ends this wait if pready never rises
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Bounded wait for the power state, then judge it
	task automatic wait_pw(input logic lvl, input int lim);
		int n;
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (powered !== lvl && n < lim);
		check({31'h0, powered}, {31'h0, lvl});
	endtask : wait_pw

	task automatic conv(input logic [31:0] cfg);
		apb(1'b1, CFG, cfg);
		wait_pw(1'b1, 10);
		wait_pw(1'b0, 4 * CV);
	endtask : conv

	task automatic t_reset();
		apb(1'b0, CFG, 32'h0);
		check(rdat, 32'(`ACMC_CFG_MODE_RST) << `ACMC_CFG_MODE_BIT);
		check({30'h0, powered, gnd_on}, 32'h0);
		apb(1'b1, RES, 32'hffffffff);
		apb(1'b0, RES, 32'h0);
		check(rdat, 32'h0);
		apb(1'b0, 8'h0c, 32'h0);
		check({31'h0, rerr}, 32'h1);
		$display("test reset done");
	endtask : t_reset

	task automatic t_single();
		apb(1'b1, CFG, TRIG | MODE);
		apb(1'b0, CFG, 32'h0);
		check(rdat, MODE);
		// Second trigger lands mid-conversion and must not start another
		apb(1'b1, CFG, TRIG | MODE);
		// Busy ends exactly CV cycles after the first trigger, not after the second
		repeat (CV - 7) @(negedge pclk);
		check({31'h0, powered}, 32'h1);
		repeat (2) @(negedge pclk);
		check({31'h0, powered}, 32'h0);
		repeat (2 * CV) @(negedge pclk);
		check({31'h0, powered}, 32'h0);
		apb(1'b0, RES, 32'h0);
		check({8'h0, rdat[23:0]}, {8'h0, 24'(-200)});
		$display("test single done");
	endtask : t_single

	task automatic t_mux();
		int er[8] = '{-200, 60, 260, -90, 100, 300, 0, 40};
		int ep[8] = '{100, 100, 300, -50, 100, 300, -50, 40};
		int en[8] = '{300, 40, 40, 40, 0, 0, 0, 0};
		for (int s = 0; s < 8; s++) begin
			conv(TRIG | MODE | 32'(s));
			check({31'h0, gnd_on}, {31'h0, s >= 4});
			check(32'(pos_in), 32'(ep[s]));
			check(32'(neg_in), 32'(en[s]));
			apb(1'b0, RES, 32'h0);
			check({8'h0, rdat[23:0]}, {8'h0, 24'(er[s])});
		end
		$display("test mux done");
	endtask : t_mux

	task automatic t_cont();
		apb(1'b1, CFG, 32'h1);
		wait_pw(1'b1, 10);
		repeat (3 * CV) @(negedge pclk);
		apb(1'b0, RES, 32'h0);
		check({8'h0, rdat[23:0]}, 32'd60);
		@(posedge pclk);
		ain[0] <= 24'sd500;
		repeat (2 * CV + 4) @(negedge pclk);
		check({31'h0, powered}, 32'h1);
		apb(1'b0, RES, 32'h0);
		check({8'h0, rdat[23:0]}, 32'd460);
		apb(1'b1, CFG, MODE | 32'h1);
		wait_pw(1'b0, 4 * CV);
		@(posedge pclk);
		ain[0] <= 24'sd100;
		$display("test continuous done");
	endtask : t_cont

	task automatic t_link();
		conv(TRIG | MODE | 32'h5);
		i_host.frame(24, r, c);
		check({31'h0, r}, 32'h0);
		check({8'h0, c}, 32'd300);
		i_host.close();
		check({31'h0, sdo_oe}, 32'h0);
		// Open frame, clock stalled low past the limit
		conv(TRIG | MODE | 32'h4);
		i_host.frame(8, r, c);
		i_host.stall(4 * TO * 5);
		i_host.close();
		apb(1'b0, RES, 32'h0);
		check(rdat, 32'h0);
		apb(1'b0, STAT, 32'h0);
		check({31'h0, rdat[`ACMC_STAT_TO]}, 32'h1);
		i_host.frame(24, r, c);
		check({8'h0, c}, 32'h0);
		i_host.close();
		$display("test link done");
	endtask : t_link

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		ain = '{24'sd100, 24'sd300, -24'sd50, 24'sd40};
		n_errors = 0;
		compares = 0;
		cyc = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_single();
		t_mux();
		t_cont();
		t_link();
		wrap_up();
	end
endmodule : adc_conversion_mux_control_tb
